// file: verilog/dual_port_block_ram_fifo.sv
// dual-port block memory with aspect ratios, split halves, ecc and fifo control
`timescale 1ns/10ps
module dual_port_block_ram_fifo
	import bram_pkg::*;
(
	input wire logic clk_i,                          // clock for both ports
	input wire logic rst_b_i,                        // async reset, active low
	input wire logic split_i,                        // two independent halves
	input wire logic simple_dual_port_mode_i,        // port a writes, port b reads
	input wire logic fifo_mode_i,                    // internal address counters
	input wire logic ecc_en_i,                       // check bits in 72-bit mode
	input wire logic latch_off_i,                    // output follows latched address
	input wire logic out_pipe_a_i,                   // extra output stage, port a
	input wire logic out_pipe_b_i,                   // extra output stage, port b
	input wire logic [2:0] width_a_i,                // aspect ratio, port a
	input wire logic [2:0] width_b_i,                // aspect ratio, port b
	input wire logic [1:0] wr_policy_a_i,            // output during write, port a
	input wire logic [1:0] wr_policy_b_i,            // output during write, port b
	input wire logic en_a_i,                         // access enable, port a
	input wire logic we_a_i,                         // write enable, port a
	input wire logic [ADDR_W-1:0] addr_a_i,          // address, port a
	input wire logic [ROW_W-1:0] din_a_i,            // write data, port a
	output logic [ROW_W-1:0] dout_a_o,               // read data, port a
	input wire logic en_b_i,                         // access enable, port b
	input wire logic we_b_i,                         // write enable, port b
	input wire logic [ADDR_W-1:0] addr_b_i,          // address, port b
	input wire logic [ROW_W-1:0] din_b_i,            // write data, port b
	output logic [ROW_W-1:0] dout_b_o,               // read data, port b
	input wire logic [PTR_W-1:0] af_thresh_i,        // almost-full fill level
	input wire logic [PTR_W-1:0] ae_thresh_i,        // almost-empty fill level
	output logic full_o,                             // fifo cannot take a write
	output logic empty_o,                            // fifo cannot give a read
	output logic almost_full_o,                      // fill at or above threshold
	output logic almost_empty_o,                     // fill at or below threshold
	output logic sbe_o,                              // corrected error on last read
	output logic dbe_o,                              // uncorrectable error on last read
	output logic cfg_err_o,                          // illegal width or mode mix
	input wire logic casc_sel_i,                     // port b shows the chained data
	input wire logic [ROW_W-1:0] casc_rdata_i,       // read data from the instance below
	output logic [ROW_W-1:0] casc_rdata_o,           // local read data to the one above
	input wire logic [DATA_W-1:0] ext_data_i,        // external word to encode or check
	input wire logic [CHK_W-1:0] ext_chk_i,          // external check bits
	output logic [CHK_W-1:0] ext_chk_o,              // generated check bits
	output logic [DATA_W-1:0] ext_data_o,            // corrected external word
	output logic ext_sbe_o,                          // external single error
	output logic ext_dbe_o                           // external double error
);
	// every flip-flop of the block except the storage array
	typedef struct packed {
		logic [ROW_W-1:0] s1_a;                  // first output stage, port a
		logic [ROW_W-1:0] s1_b;                  // first output stage, port b
		logic [ROW_W-1:0] out_a;                 // final output, port a
		logic [ROW_W-1:0] loc_b;                 // final local output, port b
		logic [ROW_W-1:0] out_b;                 // port b after cascade choice
		logic [ADDR_W-1:0] lat_a;                // last captured address, port a
		logic [ADDR_W-1:0] lat_b;                // last captured address, port b
		logic [PTR_W-1:0] wpos;                  // fifo write position in units
		logic [PTR_W-1:0] rpos;                  // fifo read position in units
		logic s1_sbe;                            // error flags beside stage one, then beside the output stage
		logic s1_dbe;
		logic sbe;
		logic dbe;
		logic [CHK_W-1:0] ext_chk;               // standalone codec results
		logic [DATA_W-1:0] ext_data;
		logic ext_sbe;
		logic ext_dbe;
	} state_t;

	state_t st_r;                                    // registered state
	state_t st_nxt;                                  // next state

	// the array is never reset, like any block memory
	logic [ROW_W-1:0] mem [ROW_CNT];

	width_mode_t wa;                                 // port a ratio
	width_mode_t wb;                                 // port b ratio
	wr_policy_t pol_a;                               // port a write policy
	wr_policy_t pol_b;                               // port b write policy
	logic sdp_eff;                                   // a write-only, b read-only
	logic cfg_bad;                                   // configuration refused
	logic a_wr, a_rd, b_wr, b_rd;                    // accepted operations
	logic [ADDR_W-1:0] addr_a, addr_b;               // addresses after muxing
	logic [ROW_AW-1:0] row_a, row_b;                 // mapped rows
	logic [OFF_W-1:0] off_a, off_b;                  // mapped offsets
	logic [ROW_W-1:0] wm_a, wm_b;                    // unshifted width masks
	logic [ROW_W-1:0] rdat_a, rdat_b;                // aligned read data
	logic [ROW_W-1:0] wdat_a;                        // port a data, ecc applied
	logic [ROW_W-1:0] rd_row_b;                      // raw row seen by port b
	logic [PTR_W-1:0] ptr_mask, cap, fill;           // fifo bookkeeping
	logic [PTR_W-1:0] inc_w, inc_r;                  // units per fifo access
	logic full, empty;                               // raw fifo flags
	logic ecc_w, ecc_r;                              // ecc active on each side
	logic [DATA_W-1:0] enc_data, dec_data, dec_fix;  // codec data words
	logic [CHK_W-1:0] enc_chk, dec_chk;              // codec check bits
	logic dec_sbe, dec_dbe;                          // codec flags for port b

	assign wa = width_mode_t'(width_a_i);
	assign wb = width_mode_t'(width_b_i);
	assign pol_a = wr_policy_t'(wr_policy_a_i);
	assign pol_b = wr_policy_t'(wr_policy_b_i);
	assign sdp_eff = simple_dual_port_mode_i | fifo_mode_i;

	// legality of the width mix; a refused setup blocks every access
	always_comb begin
		width_mode_t max_m;
		logic fix_a, fix_b;
		if (split_i) begin
			max_m = sdp_eff ? W36 : W18;
			fix_a = (wa == W36);
			fix_b = (wb == W36);
		end else begin
			max_m = sdp_eff ? W72 : W36;
			fix_a = (wa >= W36);
			fix_b = (wb >= W36);
		end
		cfg_bad = (wa > max_m) || (wb > max_m) || (wa > W72) || (wb > W72);
		// the fifo lets both widths vary; plain wide mode does not
		if (simple_dual_port_mode_i && !fifo_mode_i && !(fix_a || fix_b)) begin
			cfg_bad = 1'b1;
		end
	end
	assign cfg_err_o = cfg_bad;

	// fifo fill in units of one data bit or one lane eighth
	assign ptr_mask = split_i ? HALF_MASK : FULL_MASK;
	assign cap = split_i ? HALF_CAP : FULL_CAP;
	assign inc_w = UNIT_ONE << wa;
	assign inc_r = UNIT_ONE << wb;
	assign fill = (st_r.wpos - st_r.rpos) & ptr_mask;
	assign full = fill > (cap - inc_w);
	assign empty = fill < inc_r;
	assign full_o = fifo_mode_i & full;
	assign empty_o = !fifo_mode_i | empty;
	assign almost_full_o = fifo_mode_i & (fill >= af_thresh_i);
	assign almost_empty_o = !fifo_mode_i | (fill <= ae_thresh_i);

	// operations accepted this edge; port roles fixed in wide and fifo modes
	always_comb begin
		a_wr = !cfg_bad && en_a_i && we_a_i && !(fifo_mode_i && full);
		a_rd = !cfg_bad && en_a_i && !we_a_i && !sdp_eff;
		b_wr = !cfg_bad && en_b_i && we_b_i && !sdp_eff;
		if (fifo_mode_i) begin
			b_rd = !cfg_bad && en_b_i && !empty;
		end else begin
			b_rd = !cfg_bad && en_b_i && (!we_b_i || sdp_eff);
		end
	end

	// fifo ports walk their own pointers; otherwise idle ports keep the latched address
	always_comb begin
		logic [PTR_W-1:0] wp, rp;
		wp = st_r.wpos & ptr_mask;
		rp = st_r.rpos & ptr_mask;
		if (fifo_mode_i) begin
			addr_a = ADDR_W'(wp >> wa);
			addr_b = ADDR_W'(rp >> wb);
		end else begin
			addr_a = (a_wr || a_rd) ? addr_a_i : st_r.lat_a;
			addr_b = (b_wr || b_rd) ? addr_b_i : st_r.lat_b;
		end
	end

	// one mapper per port; the fifo keeps to the lower half when split
	lane_map map_a (
		.mode_i(width_a_i),
		.addr_i(addr_a),
		.split_i(split_i),
		.half_i(1'b0),
		.row_o(row_a),
		.off_o(off_a),
		.mask_o(wm_a)
	);

	lane_map map_b (
		.mode_i(width_b_i),
		.addr_i(addr_b),
		.split_i(split_i),
		.half_i(!fifo_mode_i),
		.row_o(row_b),
		.off_o(off_b),
		.mask_o(wm_b)
	);

	// check bits ride in the parity bit of each lane
	always_comb begin
		for (int k = 0; k < LANE_N; k++) begin
			enc_data[k*LANE_DW +: LANE_DW] = din_a_i[k*LANE_W +: LANE_DW];
			dec_data[k*LANE_DW +: LANE_DW] = rd_row_b[k*LANE_W +: LANE_DW];
			dec_chk[k] = rd_row_b[k*LANE_W + LANE_DW];
		end
	end

	secded_codec enc (
		.data_i(enc_data),
		.chk_i(8'h00),
		.chk_o(enc_chk),
		.data_o(),
		.sbe_o(),
		.dbe_o()
	);

	secded_codec dec (
		.data_i(dec_data),
		.chk_i(dec_chk),
		.chk_o(),
		.data_o(dec_fix),
		.sbe_o(dec_sbe),
		.dbe_o(dec_dbe)
	);

	logic [CHK_W-1:0] st_nxt_ext_chk;                // external codec, before the flops
	logic [DATA_W-1:0] st_nxt_ext_data;
	logic st_nxt_ext_sbe;
	logic st_nxt_ext_dbe;

	// standalone codec for memories outside the block
	secded_codec ext (
		.data_i(ext_data_i),
		.chk_i(ext_chk_i),
		.chk_o(st_nxt_ext_chk),
		.data_o(st_nxt_ext_data),
		.sbe_o(st_nxt_ext_sbe),
		.dbe_o(st_nxt_ext_dbe)
	);

	assign ecc_w = ecc_en_i && sdp_eff && (wa == W72);
	assign ecc_r = ecc_en_i && sdp_eff && (wb == W72);
	assign rd_row_b = mem[row_b];

	// aligned data for each port; port b swaps in corrected lanes under ecc
	always_comb begin
		wdat_a = din_a_i;
		rdat_a = (mem[row_a] >> off_a) & wm_a;
		rdat_b = (rd_row_b >> off_b) & wm_b;
		for (int k = 0; k < LANE_N; k++) begin
			if (ecc_w) begin
				wdat_a[k*LANE_W + LANE_DW] = enc_chk[k];
			end
			if (ecc_r) begin
				rdat_b[k*LANE_W +: LANE_DW] = dec_fix[k*LANE_DW +: LANE_DW];
			end
		end
	end

	// storage writes; a same-row clash keeps port b's write and drops port a's write to that row
	always_ff @(posedge clk_i) begin
		if (a_wr) begin
			mem[row_a] <= (mem[row_a] & ~(wm_a << off_a)) | (((wdat_a & wm_a)) << off_a);
		end
		if (b_wr) begin
			mem[row_b] <= (mem[row_b] & ~(wm_b << off_b)) | (((din_b_i & wm_b)) << off_b);
		end
	end

	// next state for the output stages, pointers and error flags
	always_comb begin
		st_nxt = st_r;
		// port a first stage
		if (a_rd) begin
			st_nxt.s1_a = rdat_a;
		end else if (a_wr && pol_a == READ_FIRST) begin
			st_nxt.s1_a = rdat_a;
		end else if (a_wr && pol_a == WRITE_FIRST) begin
			st_nxt.s1_a = wdat_a & wm_a;
		end else if (!a_wr && latch_off_i && !sdp_eff) begin
			st_nxt.s1_a = rdat_a;
		end
		// port b first stage, error flags move with its data
		if (b_rd) begin
			st_nxt.s1_b = rdat_b;
			st_nxt.s1_sbe = ecc_r && dec_sbe;
			st_nxt.s1_dbe = ecc_r && dec_dbe;
		end else if (b_wr && pol_b == READ_FIRST) begin
			st_nxt.s1_b = rdat_b;
		end else if (b_wr && pol_b == WRITE_FIRST) begin
			st_nxt.s1_b = din_b_i & wm_b;
		end else if (!b_wr && latch_off_i && !fifo_mode_i) begin
			st_nxt.s1_b = rdat_b;
		end
		// address latches keep the last operation's address
		if (a_wr || a_rd) begin
			st_nxt.lat_a = addr_a;
		end
		if (b_wr || b_rd) begin
			st_nxt.lat_b = addr_b;
		end
		// output stage: pipeline costs one extra cycle of latency
		st_nxt.out_a = out_pipe_a_i ? st_r.s1_a : st_nxt.s1_a;
		st_nxt.loc_b = out_pipe_b_i ? st_r.s1_b : st_nxt.s1_b;
		st_nxt.sbe = out_pipe_b_i ? st_r.s1_sbe : st_nxt.s1_sbe;
		st_nxt.dbe = out_pipe_b_i ? st_r.s1_dbe : st_nxt.s1_dbe;
		// chained instances pass the lower one's data through port b
		st_nxt.out_b = casc_sel_i ? casc_rdata_i : st_nxt.loc_b;
		// fifo pointers step by the width of each side
		if (fifo_mode_i && a_wr) begin
			st_nxt.wpos = (st_r.wpos + inc_w) & ptr_mask;
		end
		if (fifo_mode_i && b_rd) begin
			st_nxt.rpos = (st_r.rpos + inc_r) & ptr_mask;
		end
		// pointers rewind whenever the fifo is off, so it starts empty
		if (!fifo_mode_i) begin
			st_nxt.wpos = '0;
			st_nxt.rpos = '0;
		end
		// standalone codec results registered for a clean output
		st_nxt.ext_chk = st_nxt_ext_chk;
		st_nxt.ext_data = st_nxt_ext_data;
		st_nxt.ext_sbe = st_nxt_ext_sbe;
		st_nxt.ext_dbe = st_nxt_ext_dbe;
	end

	// single state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops
	assign dout_a_o = st_r.out_a;
	assign dout_b_o = st_r.out_b;
	assign casc_rdata_o = st_r.loc_b;
	assign sbe_o = st_r.sbe;
	assign dbe_o = st_r.dbe;
	assign ext_chk_o = st_r.ext_chk;
	assign ext_data_o = st_r.ext_data;
	assign ext_sbe_o = st_r.ext_sbe;
	assign ext_dbe_o = st_r.ext_dbe;
endmodule : dual_port_block_ram_fifo

// file: verilog/bram_pkg.sv
// shared widths, mode encodings and capacity constants for the block memory
package bram_pkg;
	localparam int ROW_W = 72;                   // bits in one storage row
	localparam int ROW_CNT = 512;                // rows in the full array
	localparam int ROW_AW = 9;                   // row address width
	localparam int HALF_AW = 8;                  // row address width of one half
	localparam int ADDR_W = 15;                  // port address width
	localparam int PTR_W = 16;                   // fifo pointer width, wrap bit included
	localparam int LANE_W = 9;                   // byte lane with its parity bit
	localparam int LANE_N = 8;                   // lanes per row
	localparam int LANE_DW = 8;                  // data bits per lane
	localparam int DATA_W = 64;                  // data bits per row
	localparam int CHK_W = 8;                    // check bits per row
	localparam int HAM_W = 7;                    // hamming part of the check bits
	localparam int OFF_W = 7;                    // bit offset inside a row
	localparam int POS_W = 6;                    // data-bit position inside a row
	localparam int LANE_SH = 3;                  // log2 of data bits per lane
	localparam logic [PTR_W-1:0] FULL_CAP = 16'h8000;   // units in the full array
	localparam logic [PTR_W-1:0] HALF_CAP = 16'h4000;   // units in one half
	localparam logic [PTR_W-1:0] FULL_MASK = 16'hffff;  // pointer wrap, full array
	localparam logic [PTR_W-1:0] HALF_MASK = 16'h7fff;  // pointer wrap, one half
	localparam logic [PTR_W-1:0] UNIT_ONE = 16'h0001;   // one unit of fill count

	// port aspect ratio, narrowest first; the code is also log2 of units per access
	typedef enum logic [2:0] {W1, W2, W4, W9, W18, W36, W72} width_mode_t;

	// what a port's data output shows while that port writes
	typedef enum logic [1:0] {READ_FIRST, WRITE_FIRST, NO_CHANGE} wr_policy_t;
endpackage : bram_pkg

// file: verilog/lane_map.sv
// maps a port address and aspect ratio onto a storage row, bit offset and width mask
`timescale 1ns/10ps
module lane_map
	import bram_pkg::*;
(
	input wire logic [2:0] mode_i,               // width_mode_t code
	input wire logic [ADDR_W-1:0] addr_i,        // address in port units
	input wire logic split_i,                    // array split in two halves
	input wire logic half_i,                     // which half this port uses
	output logic [ROW_AW-1:0] row_o,             // storage row
	output logic [OFF_W-1:0] off_o,              // first bit inside the row
	output logic [ROW_W-1:0] mask_o              // ones over the port width, unshifted
);
	// row, lane and width decode; pos picks the data bit where the access starts
	always_comb begin
		logic [ADDR_W-1:0] row_full;
		logic [ADDR_W-1:0] pos_full;
		logic [OFF_W-1:0] nbits;
		nbits = '0;
		row_full = addr_i >> (ADDR_W'(POS_W) - ADDR_W'(mode_i));
		pos_full = addr_i << mode_i;
		// half arrays keep the same ratios, one row address bit fewer
		if (split_i) begin
			row_o = {half_i, row_full[HALF_AW-1:0]};
		end else begin
			row_o = row_full[ROW_AW-1:0];
		end
		off_o = OFF_W'(pos_full[POS_W-1:LANE_SH]) * OFF_W'(LANE_W) + OFF_W'(pos_full[LANE_SH-1:0]);
		// narrow widths carry no parity, wide ones take whole lanes
		if (mode_i < 3'(W9)) begin
			nbits = OFF_W'(1) << mode_i;
		end else begin
			nbits = OFF_W'(LANE_W) << (mode_i - 3'(W9));
		end
		for (int i = 0; i < ROW_W; i++) begin
			mask_o[i] = (i < int'(nbits));
		end
	end
endmodule : lane_map

// file: verilog/secded_codec.sv
// hamming encoder and single-correct double-detect checker for one 64-bit word
`timescale 1ns/10ps
module secded_codec
	import bram_pkg::*;
(
	input wire logic [DATA_W-1:0] data_i,        // data word to encode or check
	input wire logic [CHK_W-1:0] chk_i,          // stored check bits
	output logic [CHK_W-1:0] chk_o,              // freshly generated check bits
	output logic [DATA_W-1:0] data_o,            // corrected data
	output logic sbe_o,                          // single error seen and corrected
	output logic dbe_o                           // double error seen, not correctable
);
	// codeword positions skip powers of two, which hold the hamming bits
	always_comb begin
		logic [HAM_W-1:0] pos [DATA_W];
		logic [HAM_W-1:0] ham;
		logic [HAM_W-1:0] syn;
		logic ovr;
		int p;
		p = 2;
		ham = '0;
		for (int j = 0; j < DATA_W; j++) begin
			p = p + 1;
			if ((p & (p - 1)) == 0) begin
				p = p + 1;
			end
			pos[j] = HAM_W'(p);
		end
		for (int j = 0; j < DATA_W; j++) begin
			ham = ham ^ (pos[j] & {HAM_W{data_i[j]}});
		end
		chk_o = {(^data_i) ^ (^ham), ham};
		// overall parity splits single from double errors
		syn = ham ^ chk_i[HAM_W-1:0];
		ovr = (^data_i) ^ (^chk_i);
		sbe_o = ovr;
		dbe_o = !ovr && (syn != '0);
		for (int j = 0; j < DATA_W; j++) begin
			data_o[j] = data_i[j] ^ (ovr && (pos[j] == syn));
		end
	end
endmodule : secded_codec

// file: bench/dpbf_assertions.sv
// port-level checker for the dual-port block memory and fifo
`timescale 1ns/10ps
module dpbf_assertions
	import bram_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic simple_dual_port_mode_i, // one-way ports
	input wire logic fifo_mode_i, // fifo mode
	input wire logic latch_off_i, // idle reload
	input wire logic out_pipe_a_i, // pipe a
	input wire logic [2:0] width_a_i, // ratio a
	input wire logic [2:0] width_b_i, // ratio b
	input wire logic [1:0] wr_policy_a_i, // policy a
	input wire logic en_a_i, // enable a
	input wire logic we_a_i, // write a
	input wire logic [ROW_W-1:0] din_a_i, // data in a
	input wire logic [ROW_W-1:0] dout_a_o, // data out a
	input wire logic en_b_i, // enable b
	input wire logic full_o, // full
	input wire logic empty_o, // empty
	input wire logic cfg_err_o // bad mix
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_idle_flags; // flags rest outside fifo
		!fifo_mode_i |-> empty_o && !full_o;
	endproperty
	a_idle_flags: assert property (p_idle_flags) else $error("flags wrong outside fifo");
	property p_fill; // a taken push ends empty
		fifo_mode_i && empty_o && en_a_i && we_a_i && !cfg_err_o && width_a_i >= width_b_i |=> !empty_o || !fifo_mode_i;
	endproperty
	a_fill: assert property (p_fill) else $error("push left fifo empty");
	property p_full_hold; // refused push moves nothing
		fifo_mode_i && full_o && !en_b_i |=> full_o || !fifo_mode_i;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full dropped without pop");
	property p_wide_tdp; // x72 needs one-way mode
		!fifo_mode_i && !simple_dual_port_mode_i && width_a_i == W72 |-> cfg_err_o;
	endproperty
	a_wide_tdp: assert property (p_wide_tdp) else $error("wide two-way port accepted");
	property p_sdp_fixed; // one side must be wide
		!fifo_mode_i && simple_dual_port_mode_i && width_a_i < W36 && width_b_i < W36 |-> cfg_err_o;
	endproperty
	a_sdp_fixed: assert property (p_sdp_fixed) else $error("no fixed wide side accepted");
	property p_write_first; // new data shown at once
		en_a_i && we_a_i && wr_policy_a_i == WRITE_FIRST && width_a_i == W36 && !out_pipe_a_i
			&& !simple_dual_port_mode_i && !fifo_mode_i && !cfg_err_o |=> dout_a_o == {36'h0, $past(din_a_i[35:0])};
	endproperty
	a_write_first: assert property (p_write_first) else $error("write did not show new data");
	property p_no_change; // output frozen across write
		en_a_i && we_a_i && wr_policy_a_i == NO_CHANGE && !out_pipe_a_i && !latch_off_i |=> $stable(dout_a_o);
	endproperty
	a_no_change: assert property (p_no_change) else $error("output moved on no-change write");
	property p_hold; // idle port keeps its data
		(!en_a_i && !latch_off_i)[*2] |=> $stable(dout_a_o);
	endproperty
	a_hold: assert property (p_hold) else $error("idle output changed");
endmodule : dpbf_assertions

bind dual_port_block_ram_fifo dpbf_assertions u_dpbf_assertions (.*);

// file: bench/fabric_model.sv
// user fabric model that drives port a of the block memory
`timescale 1ns/10ps
module fabric_model
	import bram_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic full_i, // fifo full
	input wire logic fifo_i, // fifo mode
	output logic en_o, // enable
	output logic we_o, // write enable
	output logic [ADDR_W-1:0] addr_o, // address
	output logic [ROW_W-1:0] din_o // write data
);
	initial begin // idle from time zero
		en_o = 1'b0;
		we_o = 1'b0;
		addr_o = '0;
		din_o = '0;
	end
	// one access held over its taking edge; a push waits out full unless raw
	task automatic access(input logic raw, input logic we, input logic [ADDR_W-1:0] ad, input logic [ROW_W-1:0] d);
		int n;
		n = 0;
		while (!raw && fifo_i && we && full_i && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		@(posedge clk_i);
		en_o <= 1'b1; // port b is never written by the bench in this cycle
		we_o <= we;
		addr_o <= ad;
		din_o <= d;
		@(posedge clk_i);
		en_o <= 1'b0;
		we_o <= 1'b0;
		din_o <= ~d; // flipped so stale data cannot pass
		#1;
	endtask : access
endmodule : fabric_model

// file: bench/dual_port_block_ram_fifo_tb.sv
// self-checking bench for the dual-port block memory and fifo
`timescale 1ns/10ps
module dual_port_block_ram_fifo_tb;
	import bram_pkg::*;
	logic clk_i = 1'b0, rst_b_i = 1'b0, split_i = 1'b0, simple_dual_port_mode_i = 1'b0; // clock, layout
	logic fifo_mode_i = 1'b0, ecc_en_i = 1'b0, latch_off_i = 1'b0, out_pipe_a_i = 1'b0, out_pipe_b_i = 1'b0; // modes
	logic [2:0] width_a_i = 3'h5, width_b_i = 3'h5; // ratios
	logic [1:0] wr_policy_a_i = 2'h0, wr_policy_b_i = 2'h0; // policies
	logic en_a_i, we_a_i, en_b_i = 1'b0, we_b_i = 1'b0, casc_sel_i = 1'b0; // controls
	logic [ADDR_W-1:0] addr_a_i, addr_b_i = 15'h0; // addresses
	logic [ROW_W-1:0] din_a_i, din_b_i = 72'h0, casc_rdata_i = 72'h0, dout_a_o, dout_b_o, casc_rdata_o, m; // data
	logic [PTR_W-1:0] af_thresh_i = 16'hc0, ae_thresh_i = 16'h40; // three words, one word
	logic full_o, empty_o, almost_full_o, almost_empty_o, sbe_o, dbe_o, cfg_err_o, ext_sbe_o, ext_dbe_o; // flags
	logic [DATA_W-1:0] ext_data_i = 64'h0, ext_data_o; // codec data
	logic [CHK_W-1:0] ext_chk_i = 8'h0, ext_chk_o, gen; // codec check bits
	int n_fail = 0, checks = 0, a; // tallies, scratch
	localparam logic [ROW_W-1:0] D1 = 72'h9a5c3d2e1f09876543, D2 = 72'h1234567890abcdef12; // patterns
	localparam logic [ROW_W-1:0] M36 = 72'hfffffffff, LD = {8{9'h0ff}}; // x36 mask, lane data bits
	dual_port_block_ram_fifo u_dual_port_block_ram_fifo (.*);
	fabric_model u_fabric_model (.clk_i(clk_i), .full_i(full_o), .fifo_i(fifo_mode_i), .en_o(en_a_i), .we_o(we_a_i),
		.addr_o(addr_a_i), .din_o(din_a_i));
	task automatic chk(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk
	// port b access, returns just after its taking edge
	task automatic op_b(input logic we, input logic [ADDR_W-1:0] ad, input logic [ROW_W-1:0] d);
		@(posedge clk_i);
		en_b_i <= 1'b1;
		we_b_i <= we;
		addr_b_i <= ad;
		din_b_i <= d;
		@(posedge clk_i);
		en_b_i <= 1'b0;
		we_b_i <= 1'b0;
		#1;
	endtask : op_b
	// layout change, then the mix verdict
	task automatic cfg(input logic s, input logic p, input logic [2:0] wa, input logic [2:0] wb, input logic e);
		@(posedge clk_i);
		split_i <= s;
		simple_dual_port_mode_i <= p;
		width_a_i <= wa;
		width_b_i <= wb;
		#1 chk(cfg_err_o, e, "mix verdict");
	endtask : cfg
	// x36 write at address 7 under a policy; output must show D1 each time
	task automatic polw(input logic [1:0] pol, input logic [ROW_W-1:0] d);
		@(posedge clk_i);
		wr_policy_a_i <= pol;
		u_fabric_model.access(1'b0, 1'b1, 15'h7, d);
		chk(dout_a_o, D1 & M36, "output during write");
	endtask : polw
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	initial begin // 40 MHz clock
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin // watchdog, far beyond the few thousand cycles needed
		#400000;
		n_fail++;
		report_and_stop();
	end
	initial begin // test sequence
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		polw(2'h1, D1);
		polw(2'h0, D2);
		polw(2'h2, ~D1);
		op_b(1'b0, 15'h7, 72'h0);
		chk(dout_b_o, ~D1 & M36, "cross-port read");
		@(posedge clk_i);
		out_pipe_b_i <= 1'b1;
		u_fabric_model.access(1'b0, 1'b1, 15'h8, D2);
		op_b(1'b0, 15'h8, 72'h0);
		chk(dout_b_o, ~D1 & M36, "pipe stage holds");
		@(posedge clk_i);
		#1 chk(dout_b_o, D2 & M36, "piped read");
		@(posedge clk_i);
		out_pipe_b_i <= 1'b0;
		casc_sel_i <= 1'b1;
		casc_rdata_i <= D1 & M36;
		op_b(1'b0, 15'h8, 72'h0);
		chk(dout_b_o, D1 & M36, "chained read");
		chk(casc_rdata_o, D2 & M36, "local data up the chain");
		repeat (3) @(posedge clk_i);
		casc_sel_i <= 1'b0;
		@(posedge clk_i) #1 chk(dout_b_o, D2 & M36, "held output");
		$display("test ports done");
		cfg(1'b0, 1'b0, 3'h6, 3'h5, 1'b1);
		cfg(1'b1, 1'b0, 3'h5, 3'h4, 1'b1);
		cfg(1'b0, 1'b1, 3'h4, 3'h3, 1'b1);
		cfg(1'b1, 1'b1, 3'h5, 3'h2, 1'b0);
		cfg(1'b0, 1'b1, 3'h6, 3'h6, 1'b0);
		u_fabric_model.access(1'b0, 1'b1, 15'h3, D1);
		for (int k = 0; k < 7; k++) begin // every port b ratio over stored row 3
			cfg(1'b0, 1'b1, 3'h6, 3'(k), 1'b0);
			a = (k < 3) ? 3 * (64 >> k) : 3 * (8 >> (k - 3));
			m = (k < 3) ? (72'h1 << (1 << k)) - 72'h1 : (72'h1 << (9 << (k - 3))) - 72'h1;
			op_b(1'b0, a[ADDR_W-1:0], 72'h0);
			chk(dout_b_o, D1 & m, "ratio read");
		end
		ecc_en_i <= 1'b1;
		u_fabric_model.access(1'b0, 1'b1, 15'h9, D2);
		op_b(1'b0, 15'h9, 72'h0);
		chk(dout_b_o & LD, D2 & LD, "checked data");
		chk({sbe_o, dbe_o}, 72'h0, "clean word flagged");
		ext_data_i <= D1[63:0];
		repeat (2) @(posedge clk_i);
		gen = ext_chk_o; // encoder output reused as stored check bits
		ext_data_i <= D1[63:0] ^ 64'h20;
		ext_chk_i <= gen;
		repeat (2) @(posedge clk_i);
		#1 chk({ext_sbe_o, ext_dbe_o, ext_data_o}, {2'b10, D1[63:0]}, "single fix");
		ext_data_i <= D1[63:0] ^ 64'h220;
		repeat (2) @(posedge clk_i);
		#1 chk({ext_sbe_o, ext_dbe_o}, 72'h1, "double seen");
		$display("test widths done");
		@(posedge clk_i);
		ecc_en_i <= 1'b0;
		fifo_mode_i <= 1'b1;
		cfg(1'b0, 1'b0, 3'h6, 3'h6, 1'b0);
		chk({empty_o, almost_empty_o, almost_full_o}, 72'h6, "fifo at rest");
		for (int i = 0; i < 3; i++) u_fabric_model.access(1'b0, 1'b1, 15'h0, D1 + 72'(i));
		chk({empty_o, almost_empty_o, almost_full_o}, 72'h1, "three words in");
		op_b(1'b0, 15'h0, 72'h0);
		chk(dout_b_o, D1, "first out");
		cfg(1'b0, 1'b0, 3'h6, 3'h5, 1'b0);
		op_b(1'b0, 15'h0, 72'h0);
		chk(dout_b_o, (D1 + 72'h1) & M36, "narrow low half");
		op_b(1'b0, 15'h0, 72'h0);
		chk(dout_b_o, (D1 + 72'h1) >> 36, "narrow high half");
		chk(almost_empty_o, 72'h1, "one word left");
		cfg(1'b0, 1'b0, 3'h6, 3'h6, 1'b0);
		op_b(1'b0, 15'h0, 72'h0);
		chk(dout_b_o, D1 + 72'h2, "last word");
		op_b(1'b0, 15'h0, 72'h0);
		chk(empty_o, 72'h1, "pop on empty");
		for (int i = 0; i < 511; i++) u_fabric_model.access(1'b0, 1'b1, 15'h0, 72'(i));
		chk(full_o, 72'h0, "one short of full");
		u_fabric_model.access(1'b0, 1'b1, 15'h0, 72'h1ff);
		chk(full_o, 72'h1, "full");
		u_fabric_model.access(1'b1, 1'b1, 15'h0, ~D1);
		for (int i = 0; i < 512; i++) begin // drain; the refused push must not appear
			op_b(1'b0, 15'h0, 72'h0);
			chk(dout_b_o, 72'(i), "drained word");
		end
		chk(empty_o, 72'h1, "drained");
		$display("test fifo done");
		@(posedge clk_i);
		fifo_mode_i <= 1'b0;
		cfg(1'b1, 1'b0, 3'h4, 3'h4, 1'b0);
		u_fabric_model.access(1'b0, 1'b1, 15'h2, D1);
		op_b(1'b1, 15'h2, D2);
		u_fabric_model.access(1'b0, 1'b0, 15'h2, 72'h0);
		op_b(1'b0, 15'h2, 72'h0);
		chk(dout_a_o, D1 & 72'h3ffff, "lower half");
		chk(dout_b_o, D2 & 72'h3ffff, "upper half");
		$display("test split done");
		report_and_stop();
	end
endmodule : dual_port_block_ram_fifo_tb
